/* core/icc_control_port.sv */
// Purpose: I2C target giving access to ten 8-bit codec control registers
// Assumes: SCL and SDA sampled by mclk_in through two flip-flops
// Notes:   Open-drain SDA as in/out/enable; power_down_pin restores register defaults
//
// What this block does
// [R1] Serves fast and fast-plus bus rates
// [R2] Address 001001 plus address select pin
// [R3] Acknowledge matching address, then every byte
// [R4] Direction bit: one reads, zero writes
// [R5] Master clocks and releases acknowledge bit
// [R6] Register address byte, then data, MSB first
// [R7] START and STOP frame each transfer
// [R8] Data changes only while clock low
// [R9] Write counter increments, wraps past 09h
// [R10] Read acknowledge sends next, wraps past 09h
// [R11] Counter holds last access plus one
// [R12] Not-acknowledge then STOP releases the bus
// [R13] Random read uses dummy write, repeated START
// [R14] Power-down pin low restores register defaults
// [R15] Host writes zero to fixed bits
// [R16] Sample rate codes, 11x invalid
// [R17] Clock reset bit releases clocks
// [R18] Bit clock edge select bit
// [R19] ADC filter select bit
// [R20] Output polarity flip bit
// [R21] ADC and DAC power bits
// [R22] ADC channel select bit
// [R23] Converter reset bit holds both converters
// [R24] Input method select bit
// [R25] Fixed bits and register 09h read zero
`timescale 1ns/1ns
module icc_control_port
    import icc_pkg::*;
(
    input  wire logic                mclk_in,
    input  wire logic                rst_n_in,
    input  wire logic                power_down_pin_n_in,
    input  wire logic                address_select_bit_in,
    input  wire logic                scl_in,
    input  wire logic                sda_in,
    output logic                     sda_out,
    output logic                     sda_oe_out,
    output icc_pkg::icc_ctrl_t       ctrl_out,
    output logic [7:0]               serial_format_out,
    output logic [7:0]               line_output_routing_out,
    output logic [7:0]               input_amp_gain_out,
    output logic [7:0]               adc_volume_out,
    output logic [7:0]               dac_volume_out,
    output logic [7:0]               soft_mute_out
);
    import icc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // State record
    typedef struct packed {
        logic [1:0]  scl_sync;
        logic [1:0]  sda_sync;
        logic [1:0]  sel_sync;
        logic        scl_d;
        logic        sda_d;
        logic        pdn_s1;
        logic        pdn_s2;
        icc_state_t  state;
        logic [3:0]  bit_cnt;
        logic [7:0]  shift;
        logic        first_byte;
        logic        is_read;
        logic        ack_drive;
        logic [7:0]  addr_cnt;
        logic [79:0] regs;
        icc_ctrl_t   ctrl;
        logic        sda_o;
        logic        sda_oe;
    } icc_core_t;

    icc_core_t core_reg;
    icc_core_t core_next;

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic scl_s;
    logic sda_s;

    // Wrap the address counter past the last register
    function automatic logic [7:0] next_addr(input logic [7:0] a);
        next_addr = (a >= LAST_ADDR) ? 8'h00 : a + 8'h01;
    endfunction

    // Mask writable bits; reserved register and fixed bits stay zero
    function automatic logic [7:0] wr_mask(input logic [7:0] a);
        if (a == CLK_RATE_OFS)      wr_mask = CLK_RATE_MSK;
        else if (a == ADC_EDGE_OFS) wr_mask = ADC_EDGE_MSK;
        else if (a == CONV_PWR_OFS) wr_mask = CONV_PWR_MSK;
        else if (a == IN_GAIN_OFS)  wr_mask = IN_GAIN_MSK;
        else if (a == MUTE_OFS)     wr_mask = MUTE_MSK;
        else if (a == RSVD_OFS)     wr_mask = 8'h00;
        else                        wr_mask = 8'hFF;
    endfunction

    function automatic logic [79:0] reg_defaults();
        logic [79:0] d;
        d = '0;
        d[IN_GAIN_OFS*8 +: 8] = IN_GAIN_RST;
        d[ADC_VOL_OFS*8 +: 8] = ADC_VOL_RST;
        d[DAC_VOL_OFS*8 +: 8] = DAC_VOL_RST;
        reg_defaults = d;
    endfunction

    // Decode control fields of registers 00h to 04h
    function automatic icc_ctrl_t decode_ctrl(input logic [79:0] r);
        icc_ctrl_t  c;
        logic [7:0] b0;
        logic [7:0] b2;
        logic [7:0] b3;
        logic [7:0] b4;
        b0 = r[CLK_RATE_OFS*8 +: 8];
        b2 = r[ADC_EDGE_OFS*8 +: 8];
        b3 = r[LINE_OUT_OFS*8 +: 8];
        b4 = r[CONV_PWR_OFS*8 +: 8];
        c.sample_rate_select      = b0[2:0];                   // R16
        c.sample_rate_valid       = b0[2:0] <= RATE_MAX_CODE;  // R16
        c.clock_reset_release     = b0[CKRST_BIT];             // R17
        c.bit_clock_edge_select   = b2[BCKE_BIT];              // R18
        c.adc_filter_select       = b2[FILT_BIT];              // R19
        c.output_polarity_flip    = b3[INV_BIT];               // R20
        c.adc_power_enable        = b4[ADC_POWER_ENABLE_BIT];              // R21
        c.dac_power_enable        = b4[DAC_POWER_ENABLE_BIT];              // R21
        c.adc_channel_select      = b4[ADSEL_BIT];             // R22
        c.input_method_select     = b4[INMTH_BIT];             // R24
        c.converter_reset_release = b4[CRST_BIT];              // R23
        c.adc_run                 = b4[ADC_POWER_ENABLE_BIT] & b4[CRST_BIT];  // R21 R23
        c.dac_run                 = b4[DAC_POWER_ENABLE_BIT] & b4[CRST_BIT];  // R21 R23
        decode_ctrl = c;
    endfunction

    // Constant images used by the asynchronous reset
    localparam logic [79:0] REG_DFLT  = reg_defaults();
    localparam icc_ctrl_t   CTRL_DFLT = decode_ctrl(REG_DFLT);

    ////////////////////////////////////////////////////////////////////////
    // Bus condition detection on synchronised pins
    assign scl_s     = core_reg.scl_sync[1];
    assign sda_s     = core_reg.sda_sync[1];
    assign scl_rise  = scl_s & ~core_reg.scl_d;
    assign scl_fall  = ~scl_s & core_reg.scl_d;
    assign start_det = scl_s & core_reg.scl_d & core_reg.sda_d & ~sda_s;  // R7
    assign stop_det  = scl_s & core_reg.scl_d & ~core_reg.sda_d & sda_s;  // R7

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        logic [7:0] rdata;
        rdata = '0;
        core_next = core_reg;
        core_next.scl_sync = {core_reg.scl_sync[0], scl_in};  // R1
        core_next.sda_sync = {core_reg.sda_sync[0], sda_in};
        core_next.sel_sync = {core_reg.sel_sync[0], address_select_bit_in};
        core_next.scl_d    = scl_s;
        core_next.sda_d    = sda_s;
        core_next.pdn_s1   = power_down_pin_n_in;
        core_next.pdn_s2   = core_reg.pdn_s1;
        // Nothing past 09h is read from the image
        if (core_reg.addr_cnt <= LAST_ADDR) begin
            rdata = core_reg.regs[core_reg.addr_cnt[3:0]*8 +: 8];
        end

        if (start_det) begin
            // Start or repeated start: take the address byte
            core_next.state    = ST_ADDR;  // R7 R13
            core_next.bit_cnt  = '0;
            core_next.sda_oe   = 1'b0;
            core_next.first_byte = 1'b1;
        end else if (stop_det) begin
            core_next.state  = ST_IDLE;  // R7 R12
            core_next.sda_oe = 1'b0;
        end else begin
            case (core_reg.state)
                ST_IDLE: begin
                    core_next.sda_oe = 1'b0;
                end
                ST_ADDR, ST_RCV: begin
                    // Shift data on clock rise, MSB first
                    if (scl_rise) begin  // R8 R6
                        core_next.shift   = {core_reg.shift[6:0], sda_s};
                        core_next.bit_cnt = core_reg.bit_cnt + 4'h1;
                    end
                    if (scl_fall && core_reg.bit_cnt == 4'h8) begin
                        core_next.bit_cnt = '0;
                        core_next.state   = ST_ACK;
                        core_next.ack_drive = 1'b1;
                        if (core_reg.state == ST_ADDR) begin
                            core_next.is_read = core_reg.shift[0];  // R4
                            if (core_reg.shift[7:2] != ADDR_FIXED ||
                                core_reg.shift[1] != core_reg.sel_sync[1]) begin
                                core_next.state     = ST_IDLE;  // R2 R3
                                core_next.ack_drive = 1'b0;
                            end
                        end else if (core_reg.first_byte) begin
                            core_next.addr_cnt   = core_reg.shift;  // R6
                            core_next.first_byte = 1'b0;
                        end else begin
                            // Store data and advance the counter
                            if (core_reg.addr_cnt <= LAST_ADDR)
                                core_next.regs[core_reg.addr_cnt[3:0]*8 +: 8] =
                                    core_reg.shift & wr_mask(core_reg.addr_cnt);  // R25
                            core_next.addr_cnt = next_addr(core_reg.addr_cnt);  // R9 R11
                        end
                        core_next.sda_o  = 1'b0;
                        core_next.sda_oe = core_next.ack_drive;  // R3 R5
                    end
                end
                ST_ACK: begin
                    // Release acknowledge at the end of its clock pulse
                    if (scl_fall) begin
                        core_next.ack_drive = 1'b0;
                        core_next.sda_oe    = 1'b0;
                        if (core_reg.is_read) begin
                            core_next.state  = ST_SEND;
                            core_next.shift  = rdata;  // R11
                            core_next.sda_o  = rdata[7];
                            core_next.sda_oe = ~rdata[7];
                            core_next.bit_cnt = 4'h1;
                            core_next.addr_cnt = next_addr(core_reg.addr_cnt);  // R10 R11
                        end else begin
                            core_next.state = ST_RCV;
                        end
                    end
                end
                ST_SEND: begin
                    if (scl_fall) begin
                        if (core_reg.bit_cnt == 4'h8) begin
                            core_next.state  = ST_MACK;
                            core_next.sda_oe = 1'b0;
                        end else begin
                            core_next.sda_o   = core_reg.shift[7 - core_reg.bit_cnt[2:0]];
                            core_next.sda_oe  = ~core_next.sda_o;
                            core_next.bit_cnt = core_reg.bit_cnt + 4'h1;
                        end
                    end
                end
                ST_MACK: begin
                    // Master acknowledge asks for the next byte
                    if (scl_rise) begin
                        core_next.ack_drive = ~sda_s;
                    end
                    if (scl_fall) begin
                        if (core_reg.ack_drive) begin
                            core_next.state    = ST_SEND;  // R10
                            core_next.shift    = rdata;
                            core_next.sda_o    = rdata[7];
                            core_next.sda_oe   = ~rdata[7];
                            core_next.bit_cnt  = 4'h1;
                            core_next.addr_cnt = next_addr(core_reg.addr_cnt);
                        end else begin
                            core_next.state  = ST_IDLE;  // R12
                            core_next.sda_oe = 1'b0;
                        end
                        core_next.ack_drive = 1'b0;
                    end
                end
                default: core_next.state = ST_IDLE;
            endcase
        end
        // Power-down pin low forces defaults
        if (!core_reg.pdn_s2) begin
            core_next.regs     = reg_defaults();  // R14
            core_next.addr_cnt = '0;
            core_next.state    = ST_IDLE;
            core_next.sda_oe   = 1'b0;
        end
        // Registered control fields follow the register image
        core_next.ctrl = decode_ctrl(core_next.regs);
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            core_reg <= '{scl_sync: 2'h3, sda_sync: 2'h3, sel_sync: 2'h0, scl_d: 1'b1, sda_d: 1'b1,
                          pdn_s1: 1'b0, pdn_s2: 1'b0, state: ST_IDLE, bit_cnt: 4'h0,
                          shift: 8'h00, first_byte: 1'b0, is_read: 1'b0, ack_drive: 1'b0,
                          addr_cnt: 8'h00, regs: REG_DFLT, ctrl: CTRL_DFLT, sda_o: 1'b0, sda_oe: 1'b0};
        end else begin
            core_reg <= core_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs from flip-flops; decoded control fields
    logic [7:0] r0;
    logic [7:0] r3;
    logic [7:0] r4;
    assign r0 = core_reg.regs[CLK_RATE_OFS*8 +: 8];
    assign r3 = core_reg.regs[LINE_OUT_OFS*8 +: 8];
    assign r4 = core_reg.regs[CONV_PWR_OFS*8 +: 8];
    assign sda_out    = core_reg.sda_o;
    assign sda_oe_out = core_reg.sda_oe;
    assign ctrl_out   = core_reg.ctrl;  // R16 R17 R18 R19 R20 R21 R22 R23 R24
    assign serial_format_out       = core_reg.regs[SER_FMT_OFS*8 +: 8];
    assign line_output_routing_out = r3;
    assign input_amp_gain_out      = core_reg.regs[IN_GAIN_OFS*8 +: 8];
    assign adc_volume_out          = core_reg.regs[ADC_VOL_OFS*8 +: 8];
    assign dac_volume_out          = core_reg.regs[DAC_VOL_OFS*8 +: 8];
    assign soft_mute_out           = core_reg.regs[MUTE_OFS*8 +: 8];

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_rsvd_reads_zero: assert property (@(posedge mclk_in) disable iff (!rst_n_in)  // R25
        core_reg.regs[RSVD_OFS*8 +: 8] == 8'h00) else $error("reserved register not zero");
    a_pdn_defaults: assert property (@(posedge mclk_in) disable iff (!rst_n_in)  // R14
        !core_reg.pdn_s2 |=> core_reg.regs == reg_defaults()) else $error("power-down left non-default");
    a_counter_wrap: assert property (@(posedge mclk_in) disable iff (!rst_n_in)  // R9
        core_reg.addr_cnt <= LAST_ADDR |=> core_reg.addr_cnt <= LAST_ADDR) else $error("counter past 09h");
    a_stop_release: assert property (@(posedge mclk_in) disable iff (!rst_n_in)  // R12
        stop_det |=> !core_reg.sda_oe && core_reg.state == ST_IDLE) else $error("bus held after stop");
    a_start_addr: assert property (@(posedge mclk_in) disable iff (!rst_n_in)  // R7
        start_det && core_reg.pdn_s2 |=> core_reg.state == ST_ADDR) else $error("start not taken");
    a_fixed_bits: assert property (@(posedge mclk_in) disable iff (!rst_n_in)  // R25
        (r4 & ~CONV_PWR_MSK) == 8'h00 && (r0 & ~CLK_RATE_MSK) == 8'h00) else $error("fixed bit set");
    a_run_gated: assert property (@(posedge mclk_in) disable iff (!rst_n_in)  // R23
        !r4[CRST_BIT] |-> !ctrl_out.adc_run && !ctrl_out.dac_run) else $error("converter run in reset");
    a_ack_low: assert property (@(posedge mclk_in) disable iff (!rst_n_in)  // R3
        core_reg.state == ST_ACK && core_reg.sda_oe |-> !core_reg.sda_o) else $error("ack not low");
endmodule

/* core/icc_pkg.sv */
// Purpose: Shared constants and types for the codec control port
// Assumes: 20 MHz system clock, bus pins sampled by that clock
// Notes:   Register map, field positions and reset values
package icc_pkg;
    localparam int         REG_COUNT    = 10;
    localparam logic [7:0] LAST_ADDR    = 8'h09;
    localparam logic [5:0] ADDR_FIXED   = 6'h09;   // Upper six address bits 001001
    // Register offsets
    localparam logic [7:0] CLK_RATE_OFS = 8'h00;
    localparam logic [7:0] SER_FMT_OFS  = 8'h01;
    localparam logic [7:0] ADC_EDGE_OFS = 8'h02;
    localparam logic [7:0] LINE_OUT_OFS = 8'h03;
    localparam logic [7:0] CONV_PWR_OFS = 8'h04;
    localparam logic [7:0] IN_GAIN_OFS  = 8'h05;
    localparam logic [7:0] ADC_VOL_OFS  = 8'h06;
    localparam logic [7:0] DAC_VOL_OFS  = 8'h07;
    localparam logic [7:0] MUTE_OFS     = 8'h08;
    localparam logic [7:0] RSVD_OFS     = 8'h09;
    // Reset values
    localparam logic [7:0] IN_GAIN_RST  = 8'h02;
    localparam logic [7:0] ADC_VOL_RST  = 8'h30;
    localparam logic [7:0] DAC_VOL_RST  = 8'h18;
    // Writable bit masks, zero bits read back as zero
    localparam logic [7:0] CLK_RATE_MSK = 8'h0F;
    localparam logic [7:0] ADC_EDGE_MSK = 8'h81;
    localparam logic [7:0] CONV_PWR_MSK = 8'h3D;
    localparam logic [7:0] IN_GAIN_MSK  = 8'h0F;
    localparam logic [7:0] MUTE_MSK     = 8'h33;
    // Field positions
    localparam int CKRST_BIT = 3;
    localparam int BCKE_BIT  = 7;
    localparam int FILT_BIT  = 0;
    localparam int INV_BIT   = 6;
    localparam int ADC_POWER_ENABLE_BIT  = 5;
    localparam int DAC_POWER_ENABLE_BIT  = 4;
    localparam int ADSEL_BIT = 3;
    localparam int INMTH_BIT = 2;
    localparam int CRST_BIT  = 0;
    // Sample-rate codes
    localparam logic [2:0] RATE_MAX_CODE = 3'h5;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_RCV  = 3'b010,
        ST_ACK  = 3'b011,
        ST_SEND = 3'b100,
        ST_MACK = 3'b101
    } icc_state_t;

    // Control fields decoded from registers 00h to 04h
    typedef struct packed {
        logic [2:0] sample_rate_select;
        logic       sample_rate_valid;
        logic       clock_reset_release;
        logic       bit_clock_edge_select;
        logic       adc_filter_select;
        logic       output_polarity_flip;
        logic       adc_power_enable;
        logic       dac_power_enable;
        logic       adc_channel_select;
        logic       input_method_select;
        logic       converter_reset_release;
        logic       adc_run;
        logic       dac_run;
    } icc_ctrl_t;
endpackage

/* test/icc_i2c_master_model.sv */
// Purpose: Behavioural bus master for the codec control port
// Assumes: SDA resolved by the bench with a pull-up, SCL driven only here
// Notes:   Bit period 8 mclk cycles (400 ns), clock parked high between frames
`timescale 1ns/1ns
module icc_i2c_master_model (
    input  wire logic       mclk_in,
    input  wire logic       sda_in,
    output logic            scl_out,
    output logic            sda_oe_out,
    output logic            rd_valid_out,
    output logic [7:0]      rd_data_out
);
    ////////////////////////////////////////////////////////////////////////////
    // Bus idle at time zero
    initial begin
        scl_out      = 1'b1;
        sda_oe_out   = 1'b0;
        rd_valid_out = 1'b0;
        rd_data_out  = 8'h00;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge mclk_in);
    endtask

    // One bit: data moves mid-low, sampled at end of high
    task automatic xfer_bit(input logic b, output logic r);
        sda_oe_out <= ~b;
        tick(2);
        scl_out <= 1'b1;
        tick(4);
        r = sda_in;
        scl_out <= 1'b0;
        tick(2);
    endtask

    // Start or repeated start; long low lets the target let go of SDA
    task automatic start();
        sda_oe_out <= 1'b0;
        tick(4);
        scl_out <= 1'b1;
        tick(4);
        sda_oe_out <= 1'b1;
        tick(4);
        scl_out <= 1'b0;
        tick(2);
    endtask

    // Stop, then clock stands high
    task automatic stop();
        sda_oe_out <= 1'b1;
        tick(4);
        scl_out <= 1'b1;
        tick(4);
        sda_oe_out <= 1'b0;
        tick(4);
    endtask

    // Byte out MSB first, then acknowledge slot with SDA released
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(d[i], r);
        end
        xfer_bit(1'b1, r);
        ack = ~r;
    endtask

    // Byte in, flagged for one cycle, then acknowledge or not
    task automatic recv_byte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(1'b1, r);
            d[i] = r;
        end
        rd_data_out  <= d;
        rd_valid_out <= 1'b1;
        tick(1);
        rd_valid_out <= 1'b0;
        xfer_bit(~ack, r);
    endtask
endmodule

/* test/tb_icc_control_port.sv */
// Purpose: Self-checking bench for the codec control port
// Assumes: Master model on the bus, open-drain SDA with pull-up
// Notes:   Register image kept in the bench, read bytes checked from a queue
`timescale 1ns/1ns
module tb_icc_control_port;
    import icc_pkg::*;
    logic       mclk_in = 1'b0;
    logic       rst_n, pdn_n, sel, scl, m_oe, d_sda, d_oe, rd_v, a;
    wire logic  sda_w;
    logic [7:0] rd_d, fmt, route, gain, avol, dvol, mute;
    icc_ctrl_t  ctrl;
    int         fail_count = 0;
    int         checks_done = 0;
    int         cnt = 0;
    logic [7:0] exp_q[$];
    logic [7:0] model[10], msk[10], dflt[10], wdat[12];

    ////////////////////////////////////////////////////////////////////////////
    // Clock and wired-AND data line
    always #25 mclk_in = ~mclk_in;
    assign sda_w = (m_oe || (d_oe && !d_sda)) ? 1'b0 : 1'b1;

    icc_control_port dut_u (.mclk_in(mclk_in), .rst_n_in(rst_n), .power_down_pin_n_in(pdn_n),
        .address_select_bit_in(sel), .scl_in(scl), .sda_in(sda_w), .sda_out(d_sda), .sda_oe_out(d_oe),
        .ctrl_out(ctrl), .serial_format_out(fmt), .line_output_routing_out(route),
        .input_amp_gain_out(gain), .adc_volume_out(avol), .dac_volume_out(dvol), .soft_mute_out(mute));
    icc_i2c_master_model mst_u (.mclk_in(mclk_in), .sda_in(sda_w), .scl_out(scl), .sda_oe_out(m_oe),
        .rd_valid_out(rd_v), .rd_data_out(rd_d));

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checks_done %0d fail_count %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Start plus own address byte
    task automatic addr(input logic rw);
        mst_u.start();
        mst_u.send_byte({ADDR_FIXED, sel, rw}, a);
        check("addr_ack", 16'(a), 16'h1);
    endtask

    // Burst write, updating the image with masks and wrap
    task automatic wr_regs(input logic [7:0] ofs, input int n);
        addr(1'b0);
        mst_u.send_byte(ofs, a);
        check("reg_ack", 16'(a), 16'h1);
        cnt = ofs;
        for (int i = 0; i < n; i++) begin
            mst_u.send_byte(wdat[i], a);
            check("data_ack", 16'(a), 16'h1);
            model[cnt] = wdat[i] & msk[cnt];
            cnt = (cnt == 9) ? 0 : cnt + 1;
        end
        mst_u.stop();
    endtask

    // Random or current read; last byte not acknowledged
    task automatic rd_regs(input logic set, input logic [7:0] ofs, input int n);
        logic [7:0] d;
        if (set) begin
            addr(1'b0);
            mst_u.send_byte(ofs, a);
            check("rd_reg_ack", 16'(a), 16'h1);
            cnt = ofs;
        end
        addr(1'b1);
        for (int i = 0; i < n; i++) begin
            exp_q.push_back(model[cnt]);
            cnt = (cnt == 9) ? 0 : cnt + 1;
            mst_u.recv_byte(i < n - 1, d);
        end
        mst_u.stop();
        check("sda_released", 16'(d_oe), 16'h0);
    endtask

    // Decoded fields and raw register outputs
    task automatic check_outputs();
        icc_ctrl_t e;
        e.sample_rate_select      = model[0][2:0];
        e.sample_rate_valid       = (model[0][2:0] <= 3'h5);
        e.clock_reset_release     = model[0][3];
        e.bit_clock_edge_select   = model[2][7];
        e.adc_filter_select       = model[2][0];
        e.output_polarity_flip    = model[3][6];
        e.adc_power_enable        = model[4][5];
        e.dac_power_enable        = model[4][4];
        e.adc_channel_select      = model[4][3];
        e.input_method_select     = model[4][2];
        e.converter_reset_release = model[4][0];
        e.adc_run                 = model[4][5] & model[4][0];
        e.dac_run                 = model[4][4] & model[4][0];
        check("ctrl", 16'(ctrl), 16'(e));
        check("fmt", 16'(fmt), 16'(model[1]));
        check("route", 16'(route), 16'(model[3]));
        check("gain", 16'(gain), 16'(model[5]));
        check("avol", 16'(avol), 16'(model[6]));
        check("dvol", 16'(dvol), 16'(model[7]));
        check("mute", 16'(mute), 16'(model[8]));
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Compare each byte the master reads against the oldest note
    always @(posedge mclk_in) begin
        if (rd_v === 1'b1) begin
            if (exp_q.size() == 0)
                check("rd_extra", 16'(rd_d), 16'hFFFF);
            else
                check("rd_byte", 16'(rd_d), 16'(exp_q.pop_front()));
        end
    end

    // Watchdog against a hung run
    initial begin
        repeat (50000) @(posedge mclk_in);
        fail_count++;
        $display("[ERR] run_time expected finish seen limit");
        report_and_stop();
    end

    // Main sequence
    initial begin
        rst_n = 1'b0;
        pdn_n = 1'b1;
        sel   = 1'b0;
        msk   = '{CLK_RATE_MSK, 8'hFF, ADC_EDGE_MSK, 8'hFF, CONV_PWR_MSK, IN_GAIN_MSK, 8'hFF, 8'hFF, MUTE_MSK, 8'h00};
        dflt  = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h30, 8'h18, 8'h00, 8'h00};
        model = dflt;
        void'($urandom(32'h961B));
        repeat (4) @(posedge mclk_in);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk_in);
        // Defaults, read across the wrap
        rd_regs(1'b1, 8'h00, 11);
        check_outputs();
        // Burst over every register and past the wrap, then current read
        // Only probe that sets fixed bits, to show they read back as zero
        for (int i = 0; i < 11; i++) wdat[i] = 8'($urandom);
        wr_regs(8'h00, 11);
        check_outputs();
        rd_regs(1'b0, 8'h00, 10);
        // Every sample rate code
        for (int c = 0; c < 8; c++) begin
            wdat[0] = (8'($urandom) & 8'h08) | 8'(c);
            wr_regs(8'h00, 1);
            check_outputs();
        end
        // Foreign address is ignored
        mst_u.start();
        mst_u.send_byte({ADDR_FIXED, ~sel, 1'b0}, a);
        check("foreign_ack", 16'(a), 16'h0);
        mst_u.stop();
        // Other address select level
        sel <= 1'b1;
        repeat (2) @(posedge mclk_in);
        wdat[0] = 8'($urandom);
        wdat[1] = 8'($urandom);
        wr_regs(8'h06, 2);
        rd_regs(1'b1, 8'h05, 3);
        check_outputs();
        // Power-down pin restores defaults and the counter
        pdn_n <= 1'b0;
        repeat (3) @(posedge mclk_in);
        pdn_n <= 1'b1;
        repeat (4) @(posedge mclk_in);
        model = dflt;
        cnt   = 0;
        check_outputs();
        rd_regs(1'b0, 8'h00, 6);
        check("pending", 16'(exp_q.size()), 16'h0);
        report_and_stop();
    end
endmodule
